// [rtl/oipc_top.sv]
// Purpose: output gating by safety inputs, mode report, start phase angles
// Assumes: pins synchronous to clk_in; AXI4-Lite register access
// Notes:   one write and one read in flight at most
// How it works
// - permit disabled: pin level and polarity have no effect
// - permit latch on: permit trip stays latched after pin recovers
// - permit polarity: high polarity needs pin high, low polarity needs low
// - emergency-off disabled: its pin is ignored
// - emergency-off enabled: its pin gates the output
// - emergency-off latch on: its trip stays latched, else not latched
// - interlock disabled: its pin is ignored
// - interlock enabled: its pin gates the output
// - interlock latch on: its trip stays latched, else not latched
// - latched fault clears only once its cause has gone
// - mode reads off while output off, else voltage or current loop
// - any phase in current regulation makes the mode current regulation
// - waves start at programmed angle on turn-on and wave switch, 0 to 359.9
// - start angle minus one disables feature; turn-on starts at zero
// - feature disabled: new wave starts at previous wave's end angle
// - start angle is phase one; others offset by their own shift
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module oipc_top (
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  input  wire logic                   remote_permit_input_in,
  input  wire logic                   estop_input_in,
  input  wire logic                   interlock_input_in,
  input  wire logic [2:0]             constant_current_regulation_in,
  input  wire logic                   wave_change_in,
  input  wire logic [11:0]            prev_end_angle_in,
  output logic                        output_enable_out,
  output logic [1:0]                  mode_out,
  output logic                        wave_start_out,
  output logic [2:0][11:0]            start_angle_out,
  output logic                        irq_out
);
  typedef struct packed {
    logic [8:0]                     ctrl;
    logic [15:0]                    phase_on;
    logic [1:0][11:0]               shift;
    logic [4:0]                     irq_st;
    logic [4:0]                     irq_en;
    oipc_pkg::oipc_out_t            ost;
    logic                           awv;
    logic [7:0]                     aw_addr;
    logic                           wv;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
    logic                           clr;
    logic                           start;
    logic [2:0][11:0]               angle;
    oipc_pkg::oipc_mode_t           mode;
  } oipc_st_t;

  localparam oipc_st_t ST_RST = '{
    ctrl: oipc_pkg::CTRL_RST, phase_on: oipc_pkg::PHASE_RST,
    shift: {oipc_pkg::SHIFT_RST, oipc_pkg::SHIFT_RST},
    irq_st: 5'h00, irq_en: 5'h00, ost: oipc_pkg::OS_OFF,
    awv: 1'b0, aw_addr: 8'h00, wv: 1'b0, w_data: 32'h0000_0000,
    w_strb: 4'h0, bvalid: 1'b0, bresp: oipc_pkg::RESP_OKAY,
    rvalid: 1'b0, rdata: 32'h0000_0000, rresp: oipc_pkg::RESP_OKAY,
    clr: 1'b0, start: 1'b0, angle: 36'h0_0000_0000,
    mode: oipc_pkg::MODE_OFF};

  oipc_st_t s_r;
  oipc_st_t s_nxt;

  logic [2:0] ch_en;
  logic [2:0] ch_latch_en;
  logic [2:0] ch_fault;
  logic [2:0] ch_block;
  logic [2:0] ch_latched;
  logic [2:0] ch_trip;

  // add two angles modulo a full circle
  function automatic logic [11:0] add_mod(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum >= oipc_pkg::ANGLE_FULL) begin
      sum = sum - oipc_pkg::ANGLE_FULL;
    end
    return sum[11:0];
  endfunction

  // merge write data into a register image by byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true for an angle within 0 to 359.9 degrees
  function automatic logic angle_ok(input logic [15:0] v);
    return (v[15:12] == 4'h0) && (v[11:0] <= oipc_pkg::ANGLE_MAX);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      oipc_pkg::ADDR_CTRL, oipc_pkg::ADDR_CLEAR, oipc_pkg::ADDR_STATUS,
      oipc_pkg::ADDR_PHASE_ON, oipc_pkg::ADDR_SHIFT2, oipc_pkg::ADDR_SHIFT3,
      oipc_pkg::ADDR_IRQ_ST, oipc_pkg::ADDR_IRQ_CLR,
      oipc_pkg::ADDR_IRQ_EN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  assign ch_en[oipc_pkg::CH_PERMIT]       = s_r.ctrl[oipc_pkg::CTRL_PERMIT_EN];
  assign ch_en[oipc_pkg::CH_ESTOP]        = s_r.ctrl[oipc_pkg::CTRL_ESTOP_EN];
  assign ch_en[oipc_pkg::CH_ILK]          = s_r.ctrl[oipc_pkg::CTRL_ILK_EN];
  assign ch_latch_en[oipc_pkg::CH_PERMIT] = s_r.ctrl[oipc_pkg::CTRL_PERMIT_LATCH];
  assign ch_latch_en[oipc_pkg::CH_ESTOP]  = s_r.ctrl[oipc_pkg::CTRL_ESTOP_LATCH];
  assign ch_latch_en[oipc_pkg::CH_ILK]    = s_r.ctrl[oipc_pkg::CTRL_ILK_LATCH];

  assign ch_fault[oipc_pkg::CH_PERMIT] = s_r.ctrl[oipc_pkg::CTRL_PERMIT_HIGH]
                                         ? ~remote_permit_input_in : remote_permit_input_in;
  assign ch_fault[oipc_pkg::CH_ESTOP]  = estop_input_in;
  assign ch_fault[oipc_pkg::CH_ILK]    = ~interlock_input_in;

  genvar g;
  generate
    for (g = 0; g < oipc_pkg::N_CH; g++) begin : g_ch
      oipc_fault_latch u_latch (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .func_en_in  (ch_en[g]),
        .latch_en_in (ch_latch_en[g]),
        .fault_in    (ch_fault[g]),
        .clear_in    (s_r.clr),
        .block_out   (ch_block[g]),
        .latched_out (ch_latched[g]),
        .trip_out    (ch_trip[g])
      );
    end
  endgenerate

  always_comb begin
    logic        go_on;
    logic        turn_on;
    logic        turn_off;
    logic        feature;
    logic [11:0] base;
    logic [31:0] img;
    logic [4:0]  ev;
    go_on    = 1'b0;
    turn_on  = 1'b0;
    turn_off = 1'b0;
    feature  = 1'b0;
    base     = 12'h000;
    img      = 32'h0000_0000;
    ev       = 5'h00;
    s_nxt    = s_r;
    s_nxt.clr   = 1'b0;
    s_nxt.start = 1'b0;

    go_on = s_r.ctrl[oipc_pkg::CTRL_OUT_ON] & ~(|ch_block);
    case (s_r.ost)
      oipc_pkg::OS_OFF: begin
        if (go_on) begin
          s_nxt.ost = oipc_pkg::OS_ON;
          turn_on   = 1'b1;
        end
      end
      oipc_pkg::OS_ON: begin
        if (!go_on) begin
          s_nxt.ost = oipc_pkg::OS_OFF;
          turn_off  = 1'b1;
        end
      end
      default: s_nxt.ost = oipc_pkg::OS_OFF;
    endcase

    if (s_nxt.ost == oipc_pkg::OS_OFF) begin
      s_nxt.mode = oipc_pkg::MODE_OFF;
    end else if (|constant_current_regulation_in) begin
      s_nxt.mode = oipc_pkg::MODE_IREG;
    end else begin
      s_nxt.mode = oipc_pkg::MODE_VREG;
    end

    feature = s_r.ctrl[oipc_pkg::CTRL_SYNC_EN] && (s_r.phase_on != oipc_pkg::PHASE_OFF);
    if (feature) begin
      base = s_r.phase_on[11:0];
    end else if (turn_on) begin
      base = 12'h000;
    end else begin
      base = prev_end_angle_in;
    end
    if (turn_on || (wave_change_in && s_r.ost == oipc_pkg::OS_ON && go_on)) begin
      s_nxt.start    = 1'b1;
      s_nxt.angle[0] = base;
      s_nxt.angle[1] = add_mod(base, s_r.shift[0]);
      s_nxt.angle[2] = add_mod(base, s_r.shift[1]);
    end

    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.awv     = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.wv     = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.awv && s_r.wv) begin
      s_nxt.awv    = 1'b0;
      s_nxt.wv     = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = mapped(s_r.aw_addr) ? oipc_pkg::RESP_OKAY : oipc_pkg::RESP_SLVERR;
      case (s_r.aw_addr)
        oipc_pkg::ADDR_CTRL: begin
          img        = merge({23'h000000, s_r.ctrl}, s_r.w_data, s_r.w_strb);
          s_nxt.ctrl = img[8:0];
        end
        oipc_pkg::ADDR_CLEAR: begin
          img       = merge(32'h0000_0000, s_r.w_data, s_r.w_strb);
          s_nxt.clr = img[oipc_pkg::CLEAR_FAULTS];
        end
        oipc_pkg::ADDR_PHASE_ON: begin
          img = merge({16'h0000, s_r.phase_on}, s_r.w_data, s_r.w_strb);
          if (angle_ok(img[15:0]) || img[15:0] == oipc_pkg::PHASE_OFF) begin
            s_nxt.phase_on = img[15:0];
          end
        end
        oipc_pkg::ADDR_SHIFT2: begin
          img = merge({20'h00000, s_r.shift[0]}, s_r.w_data, s_r.w_strb);
          if (angle_ok(img[15:0])) begin
            s_nxt.shift[0] = img[11:0];
          end
        end
        oipc_pkg::ADDR_SHIFT3: begin
          img = merge({20'h00000, s_r.shift[1]}, s_r.w_data, s_r.w_strb);
          if (angle_ok(img[15:0])) begin
            s_nxt.shift[1] = img[11:0];
          end
        end
        oipc_pkg::ADDR_IRQ_CLR: begin
          img          = merge(32'h0000_0000, s_r.w_data, s_r.w_strb);
          s_nxt.irq_st = s_r.irq_st & ~img[4:0];
        end
        oipc_pkg::ADDR_IRQ_EN: begin
          img          = merge({27'h0000000, s_r.irq_en}, s_r.w_data, s_r.w_strb);
          s_nxt.irq_en = img[4:0];
        end
        default: img = 32'h0000_0000;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // events set after clear so a same-cycle event wins
    ev[oipc_pkg::N_CH-1:0] = ch_trip;
    ev[oipc_pkg::IRQ_OFF]  = turn_off;
    ev[oipc_pkg::IRQ_ON]   = turn_on;
    s_nxt.irq_st = s_nxt.irq_st | ev;

    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = mapped(s_axi_araddr) ? oipc_pkg::RESP_OKAY : oipc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        oipc_pkg::ADDR_CTRL:     s_nxt.rdata = {23'h000000, s_r.ctrl};
        oipc_pkg::ADDR_STATUS:   s_nxt.rdata = {21'h000000, ch_fault & ch_en, 2'b00,
                                                s_r.mode, ch_latched, s_r.ost == oipc_pkg::OS_ON};
        oipc_pkg::ADDR_PHASE_ON: s_nxt.rdata = {16'h0000, s_r.phase_on};
        oipc_pkg::ADDR_SHIFT2:   s_nxt.rdata = {20'h00000, s_r.shift[0]};
        oipc_pkg::ADDR_SHIFT3:   s_nxt.rdata = {20'h00000, s_r.shift[1]};
        oipc_pkg::ADDR_IRQ_ST:   s_nxt.rdata = {27'h0000000, s_r.irq_st};
        oipc_pkg::ADDR_IRQ_EN:   s_nxt.rdata = {27'h0000000, s_r.irq_en};
        default:                 s_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready     = ~s_r.awv & ~s_r.bvalid;
  assign s_axi_wready      = ~s_r.wv & ~s_r.bvalid;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_arready     = ~s_r.rvalid;
  assign s_axi_rvalid      = s_r.rvalid;
  assign s_axi_rdata       = s_r.rdata;
  assign s_axi_rresp       = s_r.rresp;
  assign output_enable_out = s_r.ost == oipc_pkg::OS_ON;
  assign mode_out          = s_r.mode;
  assign wave_start_out    = s_r.start;
  assign start_angle_out   = s_r.angle;
  assign irq_out           = |(s_r.irq_st & s_r.irq_en);
endmodule
`default_nettype wire

// [rtl/oipc_pkg.sv]
// Purpose: shared constants for the output interlock and phase control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses below
// Notes:   angles are tenths of a degree, 0 to 3599
package oipc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CLEAR    = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_PHASE_ON = 8'h0c;
  localparam logic [7:0] ADDR_SHIFT2   = 8'h10;
  localparam logic [7:0] ADDR_SHIFT3   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h20;

  // control register fields
  localparam int CTRL_OUT_ON       = 0;
  localparam int CTRL_PERMIT_EN    = 1;
  localparam int CTRL_PERMIT_LATCH = 2;
  localparam int CTRL_PERMIT_HIGH  = 3;
  localparam int CTRL_ESTOP_EN     = 4;
  localparam int CTRL_ESTOP_LATCH  = 5;
  localparam int CTRL_ILK_EN       = 6;
  localparam int CTRL_ILK_LATCH    = 7;
  localparam int CTRL_SYNC_EN      = 8;
  localparam int CTRL_W            = 9;
  localparam logic [8:0] CTRL_RST  = 9'h000;

  // clear register field
  localparam int CLEAR_FAULTS = 0;

  // status register fields
  localparam int STAT_OUT_ON  = 0;
  localparam int STAT_LATCH0  = 1;
  localparam int STAT_MODE0   = 4;
  localparam int STAT_FAULT0  = 8;

  // fault channels
  localparam int CH_PERMIT = 0;
  localparam int CH_ESTOP  = 1;
  localparam int CH_ILK    = 2;
  localparam int N_CH      = 3;

  // interrupt status bits: one trip per channel, then output off and on
  localparam int IRQ_OFF = 3;
  localparam int IRQ_ON  = 4;
  localparam int IRQ_W   = 5;

  // phase angles
  localparam int N_PH                 = 3;
  localparam int ANG_W                = 12;
  localparam logic [15:0] PHASE_OFF   = 16'hffff;
  localparam logic [15:0] PHASE_RST   = 16'hffff;
  localparam logic [11:0] ANGLE_MAX   = 12'he0f;
  localparam logic [12:0] ANGLE_FULL  = 13'h0e10;
  localparam logic [11:0] SHIFT_RST   = 12'h000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,
    MODE_VREG = 2'b01,
    MODE_IREG = 2'b10
  } oipc_mode_t;

  typedef enum logic {
    OS_OFF = 1'b0,
    OS_ON  = 1'b1
  } oipc_out_t;
endpackage

// [rtl/oipc_fault_latch.sv]
// Purpose: one safety input channel with optional latching of its trip
// Assumes: fault_in is already polarity corrected, high means stop
// Notes:   clear is refused while the fault is still present
`timescale 1ns/1ps
`default_nettype none
module oipc_fault_latch (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic func_en_in,
  input  wire logic latch_en_in,
  input  wire logic fault_in,
  input  wire logic clear_in,
  output logic      block_out,
  output logic      latched_out,
  output logic      trip_out
);
  typedef struct packed {
    logic latched;
    logic fault_d;
  } oipc_fl_t;

  oipc_fl_t s_r;
  oipc_fl_t s_nxt;
  logic     fault_act;

  assign fault_act = func_en_in & fault_in;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.fault_d = fault_act;
    if (!func_en_in) begin
      s_nxt.latched = 1'b0;
    end else if (fault_act && latch_en_in) begin
      s_nxt.latched = 1'b1;
    end else if (clear_in && !fault_act) begin
      s_nxt.latched = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign block_out   = fault_act | s_r.latched;
  assign latched_out = s_r.latched;
  assign trip_out    = fault_act & ~s_r.fault_d;
endmodule
`default_nettype wire

// [tb/oipc_props.sv]
// Purpose: port-level checks on mode, wave start and bus answers
// Assumes: single clock domain, async active-low reset
// Notes:   bound into every oipc_top instance
`timescale 1ns/1ps
`default_nettype none
module oipc_props (
  input wire logic             clk_in,
  input wire logic             reset_n_in,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic [2:0]       constant_current_regulation_in,
  input wire logic             wave_change_in,
  input wire logic             output_enable_out,
  input wire logic [1:0]       mode_out,
  input wire logic             wave_start_out,
  input wire logic [2:0][11:0] start_angle_out,
  input wire logic             irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  mode_off_a: assert property (!output_enable_out |-> mode_out == oipc_pkg::MODE_OFF)
    else $error("mode not off while output off");
  mode_ireg_a: assert property (output_enable_out
    && $past(|constant_current_regulation_in) |-> mode_out == oipc_pkg::MODE_IREG)
    else $error("mode not current regulation");
  mode_vreg_a: assert property (output_enable_out
    && !$past(|constant_current_regulation_in) |-> mode_out == oipc_pkg::MODE_VREG)
    else $error("mode not voltage regulation");
  start_on_a: assert property ($rose(output_enable_out) |-> wave_start_out)
    else $error("no wave start at turn-on");
  start_only_on_a: assert property (wave_start_out |-> output_enable_out)
    else $error("wave start while output off");
  wave_chg_a: assert property (wave_change_in && output_enable_out ##1 output_enable_out
    |-> wave_start_out) else $error("no wave start after wave change");
  angle_range_a: assert property (wave_start_out |-> start_angle_out[0] <= oipc_pkg::ANGLE_MAX
    && start_angle_out[1] <= oipc_pkg::ANGLE_MAX && start_angle_out[2] <= oipc_pkg::ANGLE_MAX)
    else $error("start angle out of range");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  cover property ($rose(output_enable_out));
  cover property (mode_out == oipc_pkg::MODE_IREG);
  cover property (irq_out);
endmodule
bind oipc_top oipc_props props_u (.clk_in, .reset_n_in, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .constant_current_regulation_in, .wave_change_in,
  .output_enable_out, .mode_out, .wave_start_out, .start_angle_out, .irq_out);
`default_nettype wire

// [tb/oipc_host_model.sv]
// Purpose: register host issuing AXI4-Lite single transfers
// Assumes: slave answer time unknown, bench timeout ends hangs
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module oipc_host_model (
  input  wire logic        clk_in,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (!ad && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
        awaddr <= ~a;
      end
      if (!wd && wready) begin
        wd = 1'h1;
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    end
    bready <= 1'h1;
    do @(posedge clk_in); while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk_in); while (!arready);
    arvalid <= 1'h0;
    araddr <= ~a;
    rready <= 1'h1;
    do @(posedge clk_in); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_output_interlock_phase_control.sv]
// Purpose: self-checking bench for output gating, mode and start phase
// Assumes: host model drives the register bus, bench drives the pins
// Notes:   pins vector holds permit, emergency-off and interlock levels
`timescale 1ns/1ps
`default_nettype none
module tb_output_interlock_phase_control;
  logic clk_in, reset_n_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wchg, irq, oe, ws;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, mode;
  logic [2:0] pins, ireg;
  logic [11:0] pend;
  logic [2:0][11:0] sa, ang;
  int bad_count, tests_run, starts, cycles;
  oipc_host_model host_u (.clk_in, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp);
  oipc_top dut_u (.clk_in, .reset_n_in, .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .remote_permit_input_in(pins[0]), .estop_input_in(pins[1]), .interlock_input_in(pins[2]),
    .constant_current_regulation_in(ireg), .wave_change_in(wchg), .prev_end_angle_in(pend),
    .output_enable_out(oe), .mode_out(mode), .wave_start_out(ws), .start_angle_out(sa),
    .irq_out(irq));
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (ws === 1'h1) begin
      starts++;
      ang = sa;
    end
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    host_u.wr(a, v, resp);
    chk("bresp", resp, e);
    cyc(3);
  endtask
  task automatic rreg(input logic [7:0] a);
    host_u.rd(a, d, resp);
    chk("rresp", resp, oipc_pkg::RESP_OKAY);
  endtask
  task automatic ctrl(input logic [31:0] v);
    wreg(oipc_pkg::ADDR_CTRL, v, oipc_pkg::RESP_OKAY);
  endtask
  task automatic pin(input int ch, input logic v);
    @(posedge clk_in);
    pins[ch] <= v;
    cyc(3);
  endtask
  task automatic clr();
    wreg(oipc_pkg::ADDR_CLEAR, 32'h1, oipc_pkg::RESP_OKAY);
  endtask
  task automatic pulse_wave(input logic [11:0] e);
    @(posedge clk_in);
    pend <= e;
    wchg <= 1'h1;
    @(posedge clk_in);
    wchg <= 1'h0;
    cyc(3);
  endtask
  task automatic t_reset();
    rreg(oipc_pkg::ADDR_CTRL);
    chk("ctrl", d, 36'h0);
    rreg(oipc_pkg::ADDR_PHASE_ON);
    chk("phase", d, 36'hffff);
    host_u.rd(8'h40, d, resp);
    chk("unmapped", {resp, d}, {2'h2, 32'h0});
    chk("mode", mode, oipc_pkg::MODE_OFF);
  endtask
  task automatic t_chan(input int ch, input logic bad, input int en, input int lat);
    ctrl(b(0) | b(en));
    chk("on", oe, 1'h1);
    pin(ch, bad);
    chk("tripped", oe, 1'h0);
    pin(ch, !bad);
    chk("no latch", oe, 1'h1);
    ctrl(b(0));
    pin(ch, bad);
    chk("ignored", oe, 1'h1);
    pin(ch, !bad);
    ctrl(b(0) | b(en) | b(lat));
    pin(ch, bad);
    pin(ch, !bad);
    chk("latched", oe, 1'h0);
    pin(ch, bad);
    clr();
    pin(ch, !bad);
    rreg(oipc_pkg::ADDR_STATUS);
    chk("refused", {oe, d[oipc_pkg::STAT_LATCH0 + ch]}, 2'h1);
    clr();
    chk("cleared", oe, 1'h1);
  endtask
  task automatic t_pol();
    ctrl(b(0) | b(oipc_pkg::CTRL_PERMIT_EN) | b(oipc_pkg::CTRL_PERMIT_HIGH));
    chk("high pol low", oe, 1'h0);
    pin(0, 1'h1);
    chk("high pol high", oe, 1'h1);
  endtask
  task automatic t_mode();
    ctrl(b(0));
    chk("vreg", mode, oipc_pkg::MODE_VREG);
    @(posedge clk_in);
    ireg <= 3'h2;
    cyc(3);
    chk("ireg", mode, oipc_pkg::MODE_IREG);
    ctrl(32'h0);
    chk("off", mode, oipc_pkg::MODE_OFF);
  endtask
  task automatic t_phase();
    int n;
    wreg(oipc_pkg::ADDR_PHASE_ON, 32'h1c2, oipc_pkg::RESP_OKAY);
    wreg(oipc_pkg::ADDR_SHIFT2, 32'h4b0, oipc_pkg::RESP_OKAY);
    wreg(oipc_pkg::ADDR_SHIFT3, 32'h960, oipc_pkg::RESP_OKAY);
    wreg(oipc_pkg::ADDR_PHASE_ON, 32'he10, oipc_pkg::RESP_OKAY);
    rreg(oipc_pkg::ADDR_PHASE_ON);
    chk("range", d, 36'h1c2);
    ctrl(b(0));
    chk("no sync", ang, {12'h960, 12'h4b0, 12'h0});
    ctrl(32'h0);
    n = starts;
    ctrl(b(0) | b(oipc_pkg::CTRL_SYNC_EN));
    chk("on count", starts - n, 36'h1);
    chk("on start", ang, {12'hb22, 12'h672, 12'h1c2});
    pulse_wave(12'hbb8);
    chk("wave count", starts - n, 36'h2);
    chk("wave start", ang, {12'hb22, 12'h672, 12'h1c2});
    wreg(oipc_pkg::ADDR_PHASE_ON, 32'hffff, oipc_pkg::RESP_OKAY);
    pulse_wave(12'hbb8);
    chk("wave cont", ang, {12'h708, 12'h258, 12'hbb8});
    ctrl(32'h0);
    ctrl(b(0) | b(oipc_pkg::CTRL_SYNC_EN));
    chk("zero start", ang, {12'h960, 12'h4b0, 12'h0});
  endtask
  task automatic t_irq();
    ctrl(32'h0);
    wreg(oipc_pkg::ADDR_IRQ_CLR, 32'h1f, oipc_pkg::RESP_OKAY);
    wreg(oipc_pkg::ADDR_IRQ_EN, b(oipc_pkg::IRQ_ON), oipc_pkg::RESP_OKAY);
    chk("irq idle", irq, 1'h0);
    ctrl(b(0));
    chk("irq on", irq, 1'h1);
    wreg(oipc_pkg::ADDR_IRQ_EN, 32'h0, oipc_pkg::RESP_OKAY);
    chk("irq masked", irq, 1'h0);
    wreg(oipc_pkg::ADDR_IRQ_EN, b(oipc_pkg::IRQ_ON), oipc_pkg::RESP_OKAY);
    wreg(oipc_pkg::ADDR_IRQ_CLR, b(oipc_pkg::IRQ_ON), oipc_pkg::RESP_OKAY);
    chk("irq cleared", irq, 1'h0);
    wreg(oipc_pkg::ADDR_STATUS, 32'h0, oipc_pkg::RESP_OKAY);
    wreg(8'h40, 32'h0, oipc_pkg::RESP_SLVERR);
  endtask
  initial begin
    reset_n_in = 1'h0;
    pins = 3'h4;
    ireg = 3'h0;
    wchg = 1'h0;
    pend = 12'h0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'h1;
    t_reset();
    t_chan(0, 1'h1, oipc_pkg::CTRL_PERMIT_EN, oipc_pkg::CTRL_PERMIT_LATCH);
    t_chan(1, 1'h1, oipc_pkg::CTRL_ESTOP_EN, oipc_pkg::CTRL_ESTOP_LATCH);
    t_chan(2, 1'h0, oipc_pkg::CTRL_ILK_EN, oipc_pkg::CTRL_ILK_LATCH);
    t_pol();
    t_mode();
    t_phase();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
